// ==== design/mcu_timer_defines.svh ====
// Purpose: offsets, field positions, reset values and counts of the timer subsystem
// Assumes: word-wide register port, 4-bit data
// Notes:   included by the timer module, the properties and the bench
`ifndef MCU_TIMER_DEFINES_SVH
`define MCU_TIMER_DEFINES_SVH

// register offsets
`define OFS_PRESCALER_CONTROL     4'h0
`define OFS_TIMER_ONE_CONTROL     4'h1
`define OFS_TIMER_TWO_CONTROL     4'h2
`define OFS_TIMER_THREE_CONTROL   4'h3
`define OFS_DISPLAY_TIMER_CONTROL 4'h4
`define OFS_PRESCALER_RELOAD_LO   4'h5
`define OFS_PRESCALER_RELOAD_HI   4'h6
`define OFS_TIMER_ONE_RELOAD_LO   4'h7
`define OFS_TIMER_ONE_RELOAD_HI   4'h8
`define OFS_TIMER_TWO_RELOAD_LO   4'h9
`define OFS_TIMER_TWO_RELOAD_HI   4'ha
`define OFS_DISPLAY_TIMER_RELOAD  4'hb
`define OFS_FLAGS                 4'hc
`define OFS_WATCHDOG_SERVICE      4'hd

// field positions
`define BIT_PRESCALER_RUN   0
`define BIT_T1_RUN          2
`define BIT_T2_OUT_EN       3
`define BIT_T2_RUN          1
`define BIT_T2_SRC          0
`define BIT_T3_SRC          3
`define BIT_T3_RUN          2
`define BIT_LC_RUN          3
`define BIT_LC_SRC          2

// reset value of every control register
`define CTRL_RESET          4'h0

// watchdog period in instruction clocks
`define WATCHDOG_PERIOD     16'd65534
// timer 3 tap that feeds the display timer
`define T3_LC_TAP           4

`endif

// ==== design/mcu_timer_pkg.sv ====
// Purpose: types shared by the timer subsystem
// Assumes: nothing beyond the defines header
// Notes:   state lives in one packed struct
package mcu_timer_pkg;

    typedef enum logic [1:0] {
        WD_FIRST  = 2'b01,
        WD_SECOND = 2'b10
    } wd_phase_e;

    typedef struct packed {
        logic [3:0]  prescaler_control_r;
        logic [3:0]  timer_one_control_r;
        logic [3:0]  timer_two_control_r;
        logic [3:0]  timer_three_control_r;
        logic [3:0]  display_timer_control_r;
        logic [7:0]  pre_reload_r;
        logic [7:0]  pre_cnt_r;
        logic [7:0]  t1_reload_r;
        logic [7:0]  t1_cnt_r;
        logic [7:0]  t2_reload_r;
        logic [7:0]  t2_cnt_r;
        logic [15:0] t3_cnt_r;
        logic [3:0]  lc_reload_r;
        logic [3:0]  lc_cnt_r;
        logic [15:0] wd_cnt_r;
        wd_phase_e   wd_phase_r;
        logic        watchdog_flag_r;
        logic        wd_reset_r;
        logic        pre_half_r;
        logic        pwm_r;
        logic        lc_clk_r;
        logic        t3_tap_r;
        logic [2:0]  irq_r;
        logic [3:0]  rdata_r;
    } timer_state_s;

endpackage

// ==== design/mcu_timer_subsystem.sv ====
// Purpose: prescaler, timers 1/2/3, display timer and watchdog of a 4-bit controller
// Assumes: all pulse inputs are one-cycle, synchronous enables on sys_clk_in
// Notes:   4-bit registers reached over a plain address/strobe port
`include "mcu_timer_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - programmable timers count down from the software loaded division value
// - underflow after n+1 counts sets flag, reloads, keeps counting
// - fixed timer sets its flag once per fixed count of input pulses
// - 8-bit prescaler divides instruction clock by 1 to 256
// - timer 1 counts timer 2 underflow, prescaler, timer 3 underflow or counter pin
// - timer 2 counts oscillator or halved prescaler, drives pwm and pin
// - timer 3 divides by 8192 to 65536 from sub clock or prescaler
// - display timer divides timer 3 bit 4 or system clock by 1 to 16
// - watchdog 16-bit divider, period 65534 instruction clocks, sets its flag
// - second elapsed period without service issues system reset
// - watchdog runs free, no control register touches it
// - only timers 1, 2, 3 raise interrupt requests
// - one control register governs each controllable circuit
// - timer 1 source code 00 timer 2 underflow, 01 prescaler, 10 timer 3, 11 pin
// - cleared control bit stops and holds count, set resumes
module mcu_timer_subsystem
    import mcu_timer_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       instruction_clock_in,
    input  wire logic       system_clock_in,
    input  wire logic       main_oscillator_input_in,
    input  wire logic       sub_clock_input_in,
    input  wire logic       counter_pin_in,
    input  wire logic [2:0] irq_clear_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [3:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [3:0] rdata_out,
    output logic      [2:0] irq_out,
    output logic            pulse_width_output_out,
    output logic            counter_pin_out,
    output logic            counter_pin_oe_out,
    output logic            display_clock_out,
    output logic            watchdog_flag_out,
    output logic            watchdog_reset_out
);

    timer_state_s st_r;
    timer_state_s st_nxt;

    logic prescaler_output;
    logic third_timer_underflow;
    logic t1_tick;
    logic t2_tick;
    logic t3_tick;
    logic lc_tick;
    logic t1_uf;
    logic t2_uf;
    logic lc_uf;
    logic [15:0] t3_mask;
    logic [2:0]  irq_set;

    ////////////////////////////////////////////////////////////////////////////
    // count sources and underflow strobes
    always_comb
    begin
        // prescaler emits one pulse per reload+1 instruction clocks
        prescaler_output = st_r.prescaler_control_r[`BIT_PRESCALER_RUN] & instruction_clock_in
                           & (st_r.pre_cnt_r == 8'h00);
        case (st_r.timer_three_control_r[1:0])
            2'b00:   t3_mask = 16'h1fff;
            2'b01:   t3_mask = 16'h3fff;
            2'b10:   t3_mask = 16'h7fff;
            default: t3_mask = 16'hffff;
        endcase
        t3_tick = st_r.timer_three_control_r[`BIT_T3_RUN]
                  & (st_r.timer_three_control_r[`BIT_T3_SRC] ? prescaler_output
                                                              : sub_clock_input_in);
        third_timer_underflow = t3_tick & ((st_r.t3_cnt_r & t3_mask) == t3_mask);
        t2_tick = st_r.timer_two_control_r[`BIT_T2_RUN]
                  & (st_r.timer_two_control_r[`BIT_T2_SRC] ? (prescaler_output & st_r.pre_half_r)
                                                            : main_oscillator_input_in);
        t2_uf = t2_tick & (st_r.t2_cnt_r == 8'h00);
        // source select codes
        case (st_r.timer_one_control_r[1:0])
            2'b00:   t1_tick = t2_uf;
            2'b01:   t1_tick = prescaler_output;
            2'b10:   t1_tick = third_timer_underflow;
            default: t1_tick = counter_pin_in;
        endcase
        t1_tick = t1_tick & st_r.timer_one_control_r[`BIT_T1_RUN];
        t1_uf = t1_tick & (st_r.t1_cnt_r == 8'h00);
        // display timer counts a rising tap edge or the system clock enable
        lc_tick = st_r.display_timer_control_r[`BIT_LC_RUN]
                  & (st_r.display_timer_control_r[`BIT_LC_SRC] ? system_clock_in
                     : (st_r.t3_cnt_r[`T3_LC_TAP] & ~st_r.t3_tap_r));
        lc_uf = lc_tick & (st_r.lc_cnt_r == 4'h0);
        irq_set = {third_timer_underflow, t2_uf, t1_uf};
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.wd_reset_r = 1'b0;
        st_nxt.t3_tap_r = st_r.t3_cnt_r[`T3_LC_TAP];

        // prescaler
        if (st_r.prescaler_control_r[`BIT_PRESCALER_RUN] & instruction_clock_in)
        begin
            st_nxt.pre_cnt_r = (st_r.pre_cnt_r == 8'h00) ? st_r.pre_reload_r
                                                          : st_r.pre_cnt_r - 8'h01;
        end
        if (prescaler_output)
        begin
            st_nxt.pre_half_r = ~st_r.pre_half_r;
        end

        // timer 1: count down from n, reload on the n+1th pulse
        if (t1_tick)
        begin
            st_nxt.t1_cnt_r = t1_uf ? st_r.t1_reload_r : st_r.t1_cnt_r - 8'h01;
        end

        // timer 2 also toggles the pwm line on each underflow
        if (t2_tick)
        begin
            st_nxt.t2_cnt_r = t2_uf ? st_r.t2_reload_r : st_r.t2_cnt_r - 8'h01;
        end
        if (t2_uf)
        begin
            st_nxt.pwm_r = ~st_r.pwm_r;
        end

        // timer 3 up-counts; wraps within the selected ratio
        if (t3_tick)
        begin
            st_nxt.t3_cnt_r = third_timer_underflow ? 16'h0000 : st_r.t3_cnt_r + 16'h0001;
        end

        // display timer toggles its clock on underflow
        if (lc_tick)
        begin
            st_nxt.lc_cnt_r = lc_uf ? st_r.lc_reload_r : st_r.lc_cnt_r - 4'h1;
        end
        if (lc_uf)
        begin
            st_nxt.lc_clk_r = ~st_r.lc_clk_r;
        end

        // watchdog: no control bit gates it
        if (instruction_clock_in)
        begin
            if (st_r.wd_cnt_r == `WATCHDOG_PERIOD - 16'd1)
            begin
                st_nxt.wd_cnt_r = 16'h0000;
                if (st_r.wd_phase_r == WD_SECOND)
                begin
                    st_nxt.wd_reset_r = 1'b1;
                    st_nxt.wd_phase_r = WD_FIRST;
                end
                else
                begin
                    st_nxt.wd_phase_r = WD_SECOND;
                    st_nxt.watchdog_flag_r = 1'b1;
                end
            end
            else
            begin
                st_nxt.wd_cnt_r = st_r.wd_cnt_r + 16'h0001;
            end
        end

        // request flags: clear by accept/skip, set wins over clear
        st_nxt.irq_r = (st_r.irq_r & ~irq_clear_in) | irq_set;

        // register writes; control registers gate each circuit except the watchdog
        if (wr_in)
        begin
            case (addr_in)
                `OFS_PRESCALER_CONTROL:     st_nxt.prescaler_control_r = wdata_in;
                `OFS_TIMER_ONE_CONTROL:     st_nxt.timer_one_control_r = wdata_in;
                `OFS_TIMER_TWO_CONTROL:     st_nxt.timer_two_control_r = wdata_in;
                `OFS_TIMER_THREE_CONTROL:   st_nxt.timer_three_control_r = wdata_in;
                `OFS_DISPLAY_TIMER_CONTROL: st_nxt.display_timer_control_r = wdata_in;
                // reload writes also preload the counter so the next count starts at n
                `OFS_PRESCALER_RELOAD_LO:
                begin
                    st_nxt.pre_reload_r[3:0] = wdata_in;
                    st_nxt.pre_cnt_r = {st_r.pre_reload_r[7:4], wdata_in};
                end
                `OFS_PRESCALER_RELOAD_HI:
                begin
                    st_nxt.pre_reload_r[7:4] = wdata_in;
                    st_nxt.pre_cnt_r = {wdata_in, st_r.pre_reload_r[3:0]};
                end
                `OFS_TIMER_ONE_RELOAD_LO:
                begin
                    st_nxt.t1_reload_r[3:0] = wdata_in;
                    st_nxt.t1_cnt_r = {st_r.t1_reload_r[7:4], wdata_in};
                end
                `OFS_TIMER_ONE_RELOAD_HI:
                begin
                    st_nxt.t1_reload_r[7:4] = wdata_in;
                    st_nxt.t1_cnt_r = {wdata_in, st_r.t1_reload_r[3:0]};
                end
                `OFS_TIMER_TWO_RELOAD_LO:
                begin
                    st_nxt.t2_reload_r[3:0] = wdata_in;
                    st_nxt.t2_cnt_r = {st_r.t2_reload_r[7:4], wdata_in};
                end
                `OFS_TIMER_TWO_RELOAD_HI:
                begin
                    st_nxt.t2_reload_r[7:4] = wdata_in;
                    st_nxt.t2_cnt_r = {wdata_in, st_r.t2_reload_r[3:0]};
                end
                `OFS_DISPLAY_TIMER_RELOAD:
                begin
                    st_nxt.lc_reload_r = wdata_in;
                    st_nxt.lc_cnt_r = wdata_in;
                end
                // watchdog service restarts the two-period window
                `OFS_WATCHDOG_SERVICE:
                begin
                    st_nxt.wd_cnt_r = 16'h0000;
                    st_nxt.wd_phase_r = WD_FIRST;
                    st_nxt.watchdog_flag_r = 1'b0;
                end
                default: ;
            endcase
        end

        // read data one cycle after the strobe; unmapped reads zero
        st_nxt.rdata_r = 4'h0;
        if (rd_in)
        begin
            case (addr_in)
                `OFS_PRESCALER_CONTROL:     st_nxt.rdata_r = st_r.prescaler_control_r;
                `OFS_TIMER_ONE_CONTROL:     st_nxt.rdata_r = st_r.timer_one_control_r;
                `OFS_TIMER_TWO_CONTROL:     st_nxt.rdata_r = st_r.timer_two_control_r;
                `OFS_TIMER_THREE_CONTROL:   st_nxt.rdata_r = st_r.timer_three_control_r;
                `OFS_DISPLAY_TIMER_CONTROL: st_nxt.rdata_r = st_r.display_timer_control_r;
                `OFS_PRESCALER_RELOAD_LO:   st_nxt.rdata_r = st_r.pre_cnt_r[3:0];
                `OFS_PRESCALER_RELOAD_HI:   st_nxt.rdata_r = st_r.pre_cnt_r[7:4];
                `OFS_TIMER_ONE_RELOAD_LO:   st_nxt.rdata_r = st_r.t1_cnt_r[3:0];
                `OFS_TIMER_ONE_RELOAD_HI:   st_nxt.rdata_r = st_r.t1_cnt_r[7:4];
                `OFS_TIMER_TWO_RELOAD_LO:   st_nxt.rdata_r = st_r.t2_cnt_r[3:0];
                `OFS_TIMER_TWO_RELOAD_HI:   st_nxt.rdata_r = st_r.t2_cnt_r[7:4];
                `OFS_DISPLAY_TIMER_RELOAD:  st_nxt.rdata_r = st_r.lc_cnt_r;
                `OFS_FLAGS:                 st_nxt.rdata_r = {st_r.watchdog_flag_r, st_r.irq_r};
                default:                    st_nxt.rdata_r = 4'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; watchdog reset is a one-cycle pulse, cleared by the next-state default
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            st_r <= '0;
            st_r.wd_phase_r <= WD_FIRST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign rdata_out              = st_r.rdata_r;
    assign irq_out                = st_r.irq_r;
    assign pulse_width_output_out = st_r.pwm_r;
    assign counter_pin_out        = st_r.pwm_r;
    assign counter_pin_oe_out     = st_r.timer_two_control_r[`BIT_T2_OUT_EN];
    assign display_clock_out      = st_r.lc_clk_r;
    assign watchdog_flag_out      = st_r.watchdog_flag_r;
    assign watchdog_reset_out     = st_r.wd_reset_r;

endmodule

// ==== test/mcu_timer_subsystem_properties.sv ====
// Purpose: port-level properties of the timer subsystem
// Assumes: sees only the top module ports, one clock domain
// Notes:   bound to the design after the module
`include "mcu_timer_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module mcu_timer_subsystem_properties
    import mcu_timer_pkg::*;
(
    input wire logic       sys_clk_in,
    input wire logic       sys_rst_in,
    input wire logic       instruction_clock_in,
    input wire logic       system_clock_in,
    input wire logic       main_oscillator_input_in,
    input wire logic       sub_clock_input_in,
    input wire logic       counter_pin_in,
    input wire logic [2:0] irq_clear_in,
    input wire logic [3:0] addr_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [3:0] rdata_out,
    input wire logic [2:0] irq_out,
    input wire logic       pulse_width_output_out,
    input wire logic       counter_pin_oe_out,
    input wire logic       display_clock_out,
    input wire logic       watchdog_flag_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // cycles since any count source moved; outputs may only move shortly after one
    logic [3:0] quiet_r;
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || instruction_clock_in || system_clock_in || main_oscillator_input_in
            || sub_clock_input_in || counter_pin_in)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_rdata_idle;
        !rd_in |=> rdata_out == 4'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_flags_read;
        rd_in && addr_in == `OFS_FLAGS |=> rdata_out == $past({watchdog_flag_out, irq_out});
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("flag read mismatch");
    property p_irq_sticky;
        (irq_out & ~irq_clear_in) != 3'h0 |=> (irq_out & $past(irq_out & ~irq_clear_in)) == $past(irq_out & ~irq_clear_in);
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("request flag dropped");
    property p_wd_service;
        wr_in && addr_in == `OFS_WATCHDOG_SERVICE |=> !watchdog_flag_out;
    endproperty
    a_wd_service: assert property (p_wd_service) else $error("service left flag set");
    property p_oe_stable;
        !(wr_in && addr_in == `OFS_TIMER_TWO_CONTROL) |=> $stable(counter_pin_oe_out);
    endproperty
    a_oe_stable: assert property (p_oe_stable) else $error("pin enable moved without write");
    property p_pwm_cause;
        $changed(pulse_width_output_out) |-> quiet_r < 4'h6;
    endproperty
    a_pwm_cause: assert property (p_pwm_cause) else $error("pulse output moved without source");
    property p_display_cause;
        $changed(display_clock_out) |-> quiet_r < 4'h8;
    endproperty
    a_display_cause: assert property (p_display_cause) else $error("display clock moved idle");
    property p_irq_cause;
        (irq_out & ~$past(irq_out)) != 3'h0 |-> quiet_r < 4'h6;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("request without count");
    property p_wdflag_cause;
        $rose(watchdog_flag_out) |-> $past(instruction_clock_in) || $past(instruction_clock_in, 2);
    endproperty
    a_wdflag_cause: assert property (p_wdflag_cause) else $error("watchdog flag without tick");
endmodule

bind mcu_timer_subsystem mcu_timer_subsystem_properties props
(
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .instruction_clock_in(instruction_clock_in),
    .system_clock_in(system_clock_in), .main_oscillator_input_in(main_oscillator_input_in),
    .sub_clock_input_in(sub_clock_input_in), .counter_pin_in(counter_pin_in), .irq_clear_in(irq_clear_in),
    .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .pulse_width_output_out(pulse_width_output_out), .counter_pin_oe_out(counter_pin_oe_out),
    .display_clock_out(display_clock_out), .watchdog_flag_out(watchdog_flag_out)
);

// ==== test/mcu_timer_subsystem_test.sv ====
// Purpose: directed bench of the timer subsystem
// Assumes: count sources are one-cycle enables, register port as handed over
// Notes:   second watchdog period is too long for this run and is not checked
`include "mcu_timer_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module mcu_timer_subsystem_test
    import mcu_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // drive bits: {irq clear[2:0], counter pin, sub clock, oscillator, system clock, instruction}
    localparam logic [7:0] INSTR = 8'h01, SYSCK = 8'h02, OSC = 8'h04, SUB = 8'h08;
    localparam logic [7:0] PIN = 8'h10, CLR = 8'he0;
    logic       sys_clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic [7:0] drv        = 8'h00;
    logic [3:0] addr       = 4'h0;
    logic [3:0] wdata      = 4'h0;
    logic       wr         = 1'b0;
    logic       rd         = 1'b0;
    logic [3:0] rdata;
    logic [2:0] irq;
    logic       pwm, pin, pin_oe, lcd, watchdog_flag, wdr;
    int         n_mismatch = 0;
    int         n_compared = 0;

    // 125 MHz
    always #4 sys_clk_in = ~sys_clk_in;

    mcu_timer_subsystem dut
    (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .instruction_clock_in(drv[0]),
        .system_clock_in(drv[1]), .main_oscillator_input_in(drv[2]), .sub_clock_input_in(drv[3]),
        .counter_pin_in(drv[4]), .irq_clear_in(drv[7:5]), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .pulse_width_output_out(pwm),
        .counter_pin_out(pin), .counter_pin_oe_out(pin_oe), .display_clock_out(lcd),
        .watchdog_flag_out(watchdog_flag), .watchdog_reset_out(wdr)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one-cycle strobes; the extra edge keeps back-to-back calls from clashing
    task automatic wr_reg(input logic [3:0] a, input logic [3:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask

    task automatic ld8(input logic [3:0] a, input logic [7:0] v);
        wr_reg(a, v[3:0]);
        wr_reg(a + 4'h1, v[7:4]);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [3:0] exp);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        @(negedge sys_clk_in);
        chk(rdata, exp);
    endtask

    // n back-to-back pulses, then time for registered outputs to land
    task automatic pulse(input logic [7:0] m, input int n);
        @(posedge sys_clk_in);
        drv <= m;
        repeat (n) @(posedge sys_clk_in);
        drv <= 8'h00;
        repeat (3) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(`OFS_FLAGS, 4'h0);
        wr_reg(4'hf, 4'hf);
        rd_chk(4'hf, 4'h0);
    endtask

    task automatic t_watchdog;
        pulse(INSTR, 65533);
        chk(watchdog_flag, 1'b0);
        pulse(INSTR, 1);
        chk(watchdog_flag, 1'b1);
        rd_chk(`OFS_FLAGS, 4'h8);
        wr_reg(`OFS_WATCHDOG_SERVICE, 4'h0);
        pulse(8'h00, 1);
        chk({wdr, watchdog_flag}, 2'b00);
    endtask

    task automatic t_timer1;
        ld8(`OFS_TIMER_ONE_RELOAD_LO, 8'h02);
        wr_reg(`OFS_TIMER_ONE_CONTROL, 4'h7);
        pulse(PIN, 2);
        chk(irq[0], 1'b0);
        pulse(PIN, 1);
        chk(irq[0], 1'b1);
        rd_chk(`OFS_TIMER_ONE_RELOAD_LO, 4'h2);
        wr_reg(`OFS_TIMER_ONE_CONTROL, 4'h3);
        pulse(PIN, 1);
        rd_chk(`OFS_TIMER_ONE_RELOAD_LO, 4'h2);
        wr_reg(`OFS_TIMER_ONE_CONTROL, 4'h7);
        pulse(PIN, 1);
        rd_chk(`OFS_TIMER_ONE_RELOAD_LO, 4'h1);
        chk(irq, 3'b001);
        pulse(CLR, 1);
        chk(irq, 3'b000);
    endtask

    // prescaler divides by two, timer 1 by one
    task automatic t_prescaler;
        ld8(`OFS_PRESCALER_RELOAD_LO, 8'h01);
        wr_reg(`OFS_PRESCALER_CONTROL, 4'h1);
        ld8(`OFS_TIMER_ONE_RELOAD_LO, 8'h00);
        wr_reg(`OFS_TIMER_ONE_CONTROL, 4'h5);
        pulse(INSTR, 1);
        chk(irq[0], 1'b0);
        pulse(INSTR, 1);
        chk(irq[0], 1'b1);
        wr_reg(`OFS_PRESCALER_CONTROL, 4'h0);
        pulse(CLR, 1);
    endtask

    // only the pin source is pulsed, so only its code may count
    task automatic t_sources;
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(`OFS_TIMER_ONE_CONTROL, 4'h4 | 4'(c));
            pulse(PIN, 1);
            chk(irq[0], 1'(c == 3));
            pulse(CLR, 1);
        end
    endtask

    task automatic t_timer2;
        ld8(`OFS_TIMER_TWO_RELOAD_LO, 8'h00);
        wr_reg(`OFS_TIMER_TWO_CONTROL, 4'ha);
        pulse(OSC, 1);
        chk({pin_oe, pin, pwm}, 3'b111);
        chk(irq, 3'b010);
        pulse(OSC, 1);
        chk(pwm, 1'b0);
        wr_reg(`OFS_TIMER_TWO_CONTROL, 4'h0);
        pulse(CLR, 1);
    endtask

    task automatic t_timer3;
        wr_reg(`OFS_TIMER_THREE_CONTROL, 4'h4);
        pulse(SUB, 8191);
        chk(irq[2], 1'b0);
        pulse(SUB, 1);
        chk(irq[2], 1'b1);
        wr_reg(`OFS_TIMER_THREE_CONTROL, 4'h0);
    endtask

    // divide by two: level must flip every second pulse
    task automatic t_display;
        wr_reg(`OFS_DISPLAY_TIMER_RELOAD, 4'h1);
        wr_reg(`OFS_DISPLAY_TIMER_CONTROL, 4'hc);
        pulse(SYSCK, 2);
        chk(lcd, 1'b1);
        pulse(SYSCK, 2);
        chk(lcd, 1'b0);
    endtask

    // divide-by-one prescaler, halved into timer 2, whose underflow feeds timer 1 on code 00
    // the halving phase is left at 1 by the prescaler scenario, so the first pulse counts
    task automatic t_chain;
        pulse(CLR, 1);
        ld8(`OFS_PRESCALER_RELOAD_LO, 8'h00);
        ld8(`OFS_TIMER_TWO_RELOAD_LO, 8'h00);
        ld8(`OFS_TIMER_ONE_RELOAD_LO, 8'h00);
        wr_reg(`OFS_PRESCALER_CONTROL, 4'h1);
        wr_reg(`OFS_TIMER_TWO_CONTROL, 4'h3);
        wr_reg(`OFS_TIMER_ONE_CONTROL, 4'h4);
        pulse(INSTR, 1);
        chk(irq, 3'b011);
        pulse(CLR, 1);
        pulse(INSTR, 1);
        chk(irq, 3'b000);
        wr_reg(`OFS_PRESCALER_CONTROL, 4'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_watchdog();
        t_timer1();
        t_prescaler();
        t_sources();
        t_timer2();
        t_timer3();
        t_display();
        t_chain();
        test_done();
    end

    // run needs about 75000 cycles
    initial
    begin
        #(8 * 100000);
        n_mismatch++;
        test_done();
    end
endmodule
